// >>> asu_defines.vh
// Offsets, field positions, reset values and timing counts of the serial unit
`ifndef ASU_DEFINES_VH
`define ASU_DEFINES_VH
`define ASU_ADDR_CTRL1      8'h1b
`define ASU_ADDR_CTRL2      8'h1c
`define ASU_ADDR_DATA       8'h1d
`define ASU_ADDR_PINSEL     8'h2a
`define ASU_ADDR_IRCTRL     8'h2b
`define ASU_C1_TXE          7
`define ASU_C1_RXE          6
`define ASU_C1_TRANSMIT_STOP_LENGTH         5
`define ASU_C1_EVEN         4
`define ASU_C1_PE           3
`define ASU_C2_NF_HI        2
`define ASU_C2_NF_LO        1
`define ASU_C2_STOPR        0
`define ASU_PS_TXSEL        2
`define ASU_PS_RXSEL        1
`define ASU_CTRL1_RST       8'h00
`define ASU_CTRL2_RST       3'h0
`define ASU_PINSEL_RST      2'h0
`define ASU_DATA_RST        8'h00
`define ASU_SUBTICKS        16
`define ASU_NF1_CYC         8'd31
`define ASU_NF2_CYC         8'd63
`define ASU_NF3_CYC         8'd127
`define ASU_IR_WIDTH        3
`endif

// >>> asu_baud_gen.v
// Sub-bit tick generator: fixed dividers of the system clock or timer match
`timescale 1ns/1ps
module asu_baud_gen (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire [2:0] select_i,
  input  wire       timer_match_i,
  output reg        tick_o
);
  reg  [8:0] count;
  reg  [8:0] limit;

  always @* begin
    case (select_i)
      3'h0: limit = 9'h00c;
      3'h1: limit = 9'h019;
      3'h2: limit = 9'h033;
      3'h3: limit = 9'h067;
      3'h4: limit = 9'h0cf;
      3'h5: limit = 9'h19f;
      3'h7: limit = 9'h05f;
      default: limit = 9'h000;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count  <= 9'h000;
      tick_o <= 1'b0;
    end else if (select_i == 3'h6) begin
      count  <= 9'h000;
      tick_o <= timer_match_i;
    end else if (count >= limit) begin
      count  <= 9'h000;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 9'h001;
      tick_o <= 1'b0;
    end
  end
endmodule // asu_baud_gen

// >>> asu_rx_filter.v
// Receive input synchroniser and selectable noise filter
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_rx_filter (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire       pin_i,
  input  wire [1:0] mode_i,
  output reg        level_o
);
  reg  [2:0] sync;
  reg  [7:0] run;
  reg  [7:0] need;

  always @* begin
    case (mode_i)
      2'h1: need = `ASU_NF1_CYC;
      2'h2: need = `ASU_NF2_CYC;
      2'h3: need = `ASU_NF3_CYC;
      default: need = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync    <= 3'h7;
      run     <= 8'h00;
      level_o <= 1'b1;
    end else begin
      sync <= {sync[1:0], pin_i};
      if (sync[2] != sync[1]) begin
        run <= 8'h00;
      end else if (sync[2] == level_o) begin
        run <= 8'h00;
      end else if (mode_i == 2'h0 || run >= need) begin
        level_o <= sync[2];
        run     <= 8'h00;
      end else begin
        run <= run + 8'h01;
      end
    end
  end
endmodule // asu_rx_filter

// >>> asu_uart.v
// Asynchronous serial transceiver with register port and pin routing
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_uart (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       write_i,
  input  wire       read_i,
  output reg  [7:0] rdata_o,
  input  wire       timer_match_i,
  input  wire       p42_i,
  input  wire       p45_i,
  output reg        p41_o,
  output reg        p44_o,
  output reg        p41_oe_o,
  output reg        p44_oe_o,
  output reg        transmit_interrupt_o,
  output reg        serial_interrupt_o
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SEND = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_RECV = 2'h1;

  reg  [7:0] ctrl1;
  reg  [2:0] ctrl2;
  reg  [1:0] pinsel;
  reg        ir_enable;
  reg  [7:0] transmit_buffer;
  reg  [7:0] receive_buffer;
  reg        parity_error_flag;
  reg        framing_error_flag;
  reg        overrun_flag;
  reg        receive_full_flag;
  reg        transmit_done_flag;
  reg        transmit_empty_flag;
  reg        status_seen_rx;
  reg        status_seen_tx;
  reg        tx_pending;
  reg  [1:0] tx_state;
  reg  [11:0] tx_shift;
  reg  [3:0] tx_bits;
  reg  [3:0] tx_sub;
  reg        tx_line;
  reg  [1:0] rx_state;
  reg  [3:0] rx_sub;
  reg  [3:0] rx_bits;
  reg  [10:0] rx_shift;
  reg  [1:0] rx_votes;
  reg        rx_prev;
  wire       tick;
  wire       rx_level;
  wire       rx_pin;
  wire       tx_en;
  wire       rx_en;
  wire [3:0] tx_len;
  wire [3:0] rx_len;
  wire       parity_odd;
  wire       rx_bit;
  wire       wr_data;
  wire       rd_data;
  wire       rd_status;
  wire       rx_done;
  wire [7:0] rx_byte;
  wire       rx_par_bad;
  wire       rx_stop_bad;

  assign tx_en      = ctrl1[`ASU_C1_TXE];
  assign rx_en      = ctrl1[`ASU_C1_RXE];
  assign parity_odd = ~ctrl1[`ASU_C1_EVEN];
  assign wr_data    = write_i && addr_i == `ASU_ADDR_DATA;
  assign rd_data    = read_i && addr_i == `ASU_ADDR_DATA;
  assign rd_status  = read_i && addr_i == `ASU_ADDR_CTRL1;
  // Frame length in bits: start, 8 data, parity, stops
  assign tx_len = 4'h9 + {3'h0, ctrl1[`ASU_C1_PE]} + {3'h0, ctrl1[`ASU_C1_TRANSMIT_STOP_LENGTH]} + 4'h1;
  assign rx_len = 4'h9 + {3'h0, ctrl1[`ASU_C1_PE]} + {3'h0, ctrl2[`ASU_C2_STOPR]} + 4'h1;
  assign rx_pin = pinsel[0] ? p45_i : p42_i;
  assign rx_bit = (rx_votes == 2'h2) || (rx_votes == 2'h1 && rx_level);

  // Parity of a byte with the selected type
  function parity_of;
    input [7:0] data;
    input       odd;
    begin
      parity_of = ^data ^ odd;
    end
  endfunction

  asu_baud_gen u_baud (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .select_i      (ctrl1[2:0]),
    .timer_match_i (timer_match_i),
    .tick_o        (tick)
  );

  asu_rx_filter u_filter (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (rx_pin),
    .mode_i    (ctrl2[`ASU_C2_NF_HI:`ASU_C2_NF_LO]),
    .level_o   (rx_level)
  );

  // Register writes
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl1           <= `ASU_CTRL1_RST;
      ctrl2           <= `ASU_CTRL2_RST;
      pinsel          <= `ASU_PINSEL_RST;
      ir_enable       <= 1'b0;
      transmit_buffer <= `ASU_DATA_RST;
    end else if (write_i) begin
      case (addr_i)
        `ASU_ADDR_CTRL1:  ctrl1 <= wdata_i;
        `ASU_ADDR_CTRL2:  ctrl2 <= wdata_i[2:0];
        `ASU_ADDR_PINSEL: pinsel <= {wdata_i[`ASU_PS_TXSEL], wdata_i[`ASU_PS_RXSEL]};
        `ASU_ADDR_IRCTRL: ir_enable <= wdata_i[0];
        `ASU_ADDR_DATA:   transmit_buffer <= wdata_i;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (read_i) begin
      case (addr_i)
        `ASU_ADDR_CTRL1: rdata_o <= {parity_error_flag, framing_error_flag, overrun_flag,
                                     receive_full_flag, transmit_done_flag,
                                     transmit_empty_flag, 2'h0};
        `ASU_ADDR_DATA:   rdata_o <= receive_buffer;
        `ASU_ADDR_PINSEL: rdata_o <= {5'h00, pinsel, 1'b0};
        `ASU_ADDR_IRCTRL: rdata_o <= {7'h00, ir_enable};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Transmitter
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_state             <= TX_IDLE;
      tx_shift             <= 12'hfff;
      tx_bits              <= 4'h0;
      tx_sub               <= 4'h0;
      tx_line              <= 1'b1;
      tx_pending           <= 1'b0;
      status_seen_tx       <= 1'b0;
      transmit_empty_flag  <= 1'b1;
      transmit_done_flag   <= 1'b1;
      transmit_interrupt_o <= 1'b0;
    end else begin
      transmit_interrupt_o <= 1'b0;
      if (rd_status) begin
        status_seen_tx <= 1'b1;
      end
      if (wr_data && status_seen_tx && tx_en) begin
        tx_pending          <= 1'b1;
        transmit_empty_flag <= 1'b0;
        status_seen_tx      <= 1'b0;
      end
      case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_pending && tx_en && tick) begin
            tx_shift <= {2'h3, ctrl1[`ASU_C1_PE] ?
                         {parity_of(transmit_buffer, parity_odd), transmit_buffer} :
                         {1'b1, transmit_buffer}, 1'b0};
            tx_bits              <= 4'h0;
            tx_sub               <= 4'h0;
            tx_pending           <= 1'b0;
            tx_state             <= TX_SEND;
            transmit_empty_flag  <= 1'b1;
            transmit_done_flag   <= 1'b0;
            transmit_interrupt_o <= 1'b1;
          end
        end
        TX_SEND: begin
          tx_line <= tx_shift[0];
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hf) begin
              tx_shift <= {1'b1, tx_shift[11:1]};
              tx_bits  <= tx_bits + 4'h1;
              if (tx_bits == tx_len - 4'h1) begin
                tx_state <= TX_IDLE;
                if (!tx_pending) begin
                  transmit_done_flag <= 1'b1;
                end
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Infrared shaping: low pulse of a few sub-ticks per zero bit
  wire tx_out = ir_enable ? !(tx_state == TX_SEND && !tx_line && tx_sub < `ASU_IR_WIDTH)
                          : tx_line;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p41_o    <= 1'b1;
      p44_o    <= 1'b1;
      p41_oe_o <= 1'b0;
      p44_oe_o <= 1'b0;
    end else begin
      p41_o    <= pinsel[1] ? 1'b1 : tx_out;
      p44_o    <= pinsel[1] ? tx_out : 1'b1;
      p41_oe_o <= !pinsel[1];
      p44_oe_o <= pinsel[1];
    end
  end

  // Receiver
  assign rx_byte     = rx_shift[8:1];
  assign rx_par_bad  = ctrl1[`ASU_C1_PE] &&
                       (rx_shift[9] != parity_of(rx_byte, parity_odd));
  assign rx_stop_bad = !rx_bit;
  assign rx_done     = rx_state == RX_RECV && tick && rx_sub == 4'h9 &&
                       rx_bits == rx_len - 4'h1;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state           <= RX_IDLE;
      rx_sub             <= 4'h0;
      rx_bits            <= 4'h0;
      rx_shift           <= 11'h000;
      rx_votes           <= 2'h0;
      rx_prev            <= 1'b1;
      receive_buffer     <= `ASU_DATA_RST;
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_flag       <= 1'b0;
      receive_full_flag  <= 1'b0;
      status_seen_rx     <= 1'b0;
      serial_interrupt_o <= 1'b0;
    end else begin
      serial_interrupt_o <= 1'b0;
      rx_prev            <= rx_level;
      if (rd_status) begin
        status_seen_rx <= 1'b1;
      end
      if (rd_data && status_seen_rx) begin
        parity_error_flag  <= 1'b0;
        framing_error_flag <= 1'b0;
        overrun_flag       <= 1'b0;
        receive_full_flag  <= 1'b0;
        status_seen_rx     <= 1'b0;
      end
      case (rx_state)
        RX_IDLE: begin
          if (rx_en && !overrun_flag && rx_prev && !rx_level) begin
            rx_state <= RX_RECV;
            rx_sub   <= 4'h0;
            rx_bits  <= 4'h0;
            rx_votes <= 2'h0;
          end
        end
        RX_RECV: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub >= 4'h7 && rx_sub <= 4'h8) begin
              rx_votes <= rx_votes + {1'b0, rx_level};
            end
            if (rx_sub == 4'h9) begin
              rx_shift <= rx_shift | ({10'h000, rx_bit} << rx_bits);
              rx_votes <= 2'h0;
              rx_bits  <= rx_bits + 4'h1;
              if (rx_bits == 4'h0 && rx_bit) begin
                rx_state <= RX_IDLE;
              end
            end
            if (rx_sub == 4'hf && rx_bits == rx_len) begin
              rx_state <= RX_IDLE;
            end
            if (rx_bits == 4'h0 && rx_sub == 4'h0) begin
              rx_shift <= 11'h000;
            end
          end
          if (rx_done) begin
            rx_state           <= RX_IDLE;
            serial_interrupt_o <= 1'b1;
            if (receive_full_flag && !(rd_data && status_seen_rx)) begin
              overrun_flag <= 1'b1;
            end else begin
              receive_buffer     <= rx_byte;
              receive_full_flag  <= 1'b1;
              parity_error_flag  <= rx_par_bad;
              framing_error_flag <= rx_stop_bad;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
endmodule // asu_uart

// >>> asu_uart_assertions.sv
// Port-level checks of the serial unit
`timescale 1ns/1ps
module asu_uart_assertions (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic       read_i,
  input wire logic [7:0] rdata_o,
  input wire logic       p41_o,
  input wire logic       p44_o,
  input wire logic       p41_oe_o,
  input wire logic       p44_oe_o,
  input wire logic       transmit_interrupt_o,
  input wire logic       serial_interrupt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire line = p44_oe_o ? p44_o : p41_o;
  property p_rd_idle;
    !$past(read_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_wo_read;
    read_i && addr_i == 8'h1c |=> rdata_o == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read back");
  property p_stat_low;
    read_i && addr_i == 8'h1b |=> rdata_o[1:0] == 2'b00;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits set");
  property p_oe_one;
    $past(reset_n_i) |-> p41_oe_o != p44_oe_o;
  endproperty
  a_oe_one: assert property (p_oe_one) else $error("not one transmit pin");
  property p_unsel;
    (p41_oe_o || p41_o) && (p44_oe_o || p44_o);
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected pin low");
  property p_tx_pulse;
    transmit_interrupt_o |=> !transmit_interrupt_o;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("long transmit event");
  property p_rx_pulse;
    serial_interrupt_o |=> !serial_interrupt_o;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("long receive event");
  property p_tx_start;
    transmit_interrupt_o |-> ##[0:2] !line;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
endmodule // asu_uart_assertions

bind asu_uart asu_uart_assertions u_chk (
  .clk_i, .reset_n_i, .addr_i, .read_i, .rdata_o, .p41_o, .p44_o, .p41_oe_o,
  .p44_oe_o, .transmit_interrupt_o, .serial_interrupt_o
);

// >>> asu_remote_uart.sv
// Behavioural remote serial device on the far side of the pins
`timescale 1ns/1ps
module asu_remote_uart (
  input  wire logic line_i,
  output logic      line_o
);
  int          bit_ns = 256;
  int          cap_n = 0;
  logic [11:0] cap;
  initial line_o = 1'b1;
  // Frame from start bit, data least first, parity, high stops
  function automatic logic [11:0] frame(input logic [7:0] d, input logic pe, input logic ev);
    frame = {2'b11, ev ? ^d : ~^d, d, 1'b0};
    if (!pe) frame[9] = 1'b1;
  endfunction
  // Samples each incoming frame mid-bit
  always @(negedge line_i) begin
    #(bit_ns / 2);
    for (int i = 0; i < 12; i++) begin
      cap[i] = line_i;
      #(bit_ns);
    end
    cap_n++;
  end
  // Sends one frame, with bad parity or a low last stop on request
  task automatic send(input logic [7:0] d, input logic pe, ev, two, bad_par, bad_stop);
    logic [11:0] f;
    int          n;
    f = frame(d, pe, ev);
    n = 10 + pe + two;
    f[9] = f[9] ^ bad_par;
    if (bad_stop) f[n - 1] = 1'b0;
    for (int i = 0; i < n; i++) begin
      line_o = f[i];
      #(bit_ns);
    end
    line_o = 1'b1;
  endtask
  // Drives one short low pulse on the line
  task automatic glitch(input int ns);
    line_o = 1'b0;
    #(ns);
    line_o = 1'b1;
  endtask
endmodule // asu_remote_uart

// >>> asu_uart_tb.sv
// Self-checking bench of the serial unit
`timescale 1ns/1ps
module asu_uart_tb;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       write_i = 1'b0;
  logic       read_i = 1'b0;
  logic       tmr = 1'b0;
  logic       rx45 = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] s;
  logic       p41_o, p44_o, p41_oe_o, p44_oe_o, far, line;
  int         err_total = 0;
  int         samples_checked = 0;
  assign line = p44_oe_o ? p44_o : p41_o;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) tmr <= ~tmr;
  asu_uart DUT (
    .clk_i, .reset_n_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o,
    .timer_match_i(tmr), .p42_i(far | rx45), .p45_i(far | ~rx45), .p41_o, .p44_o,
    .p41_oe_o, .p44_oe_o, .transmit_interrupt_o(), .serial_interrupt_o()
  );
  asu_remote_uart u_far (.line_i(line), .line_o(far));
  task chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task tx_one(input logic [7:0] c, input logic [7:0] d);
    int n0;
    int k;
    n0 = u_far.cap_n;
    k = 0;
    wr(8'h1b, c & 8'h3f);
    wr(8'h1b, c);
    repeat (40) @(posedge clk_i);
    chk(line, 1'b1, "idle line");
    chk(12'(u_far.cap_n), 12'(n0), "stale frame");
    rd(8'h1b, s);
    chk(s[2], 1'b1, "buffer empty");
    wr(8'h1d, d);
    if (c[2:0] == 3'b110) begin
      repeat (60) @(posedge clk_i);
      wr(8'h1b, c & 8'h3f);
    end
    while (u_far.cap_n == n0 && k < 40000) begin
      @(posedge clk_i);
      k++;
    end
    chk(12'(u_far.cap_n), 12'(n0 + 1), "frame count");
    chk(u_far.cap, u_far.frame(d, c[3], c[4]), "tx frame");
    rd(8'h1b, s);
    chk(s, 8'h0c, "tx flags");
  endtask
  task rx_one(input logic [7:0] d, input logic bp, input logic [7:0] es);
    u_far.send(d, 1'b1, 1'b1, 1'b1, bp, 1'b0);
    repeat (20) @(posedge clk_i);
    rd(8'h1b, s);
    chk(s, es, "rx status");
    rd(8'h1d, s);
    chk(s, d, "rx data");
    rd(8'h1b, s);
    chk(s, 8'h0c, "rx flags");
  endtask
  task t_reset;
    @(posedge clk_i);
    #1 chk({p41_oe_o, p41_o, p44_o}, 3'b111, "pins");
    rd(8'h1b, s);
    chk(s, 8'h0c, "status reset");
    rd(8'h1d, s);
    chk(s, 8'h00, "buffer reset");
  endtask
  task t_rx;
    wr(8'h1b, 8'h7e);
    wr(8'h1c, 8'h01);
    rx_one(8'h5a, 1'b0, 8'h1c);
    rx_one(8'hc3, 1'b1, 8'h9c);
    u_far.send(8'h11, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    u_far.send(8'h22, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    rd(8'h1b, s);
    chk(s, 8'h3c, "overrun");
    rd(8'h1d, s);
    chk(s, 8'h11, "kept data");
  endtask
  task t_pins;
    wr(8'h1b, 8'h2e);
    wr(8'h2a, 8'h04);
    repeat (2) @(posedge clk_i);
    chk({p44_oe_o, p41_oe_o}, 2'b10, "pin enables");
    rd(8'h2a, s);
    chk(s[2:1], 2'b10, "pin select");
    tx_one(8'hee, 8'h69);
    wr(8'h1b, 8'h2e);
    wr(8'h2a, 8'h02);
    rx45 <= 1'b1;
    wr(8'h1b, 8'h7e);
    rx_one(8'h96, 1'b0, 8'h1c);
    wr(8'h1b, 8'h3e);
    wr(8'h2a, 8'h00);
    rx45 <= 1'b0;
  endtask
  task t_framing;
    wr(8'h1b, 8'h0e);
    wr(8'h1b, 8'hce);
    wr(8'h1c, 8'h00);
    u_far.send(8'h77, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (20) @(posedge clk_i);
    rd(8'h1b, s);
    chk(s[6], 1'b1, "framing flag");
    rd(8'h1d, s);
    wr(8'h1c, 8'h02);
    u_far.glitch(160);
    repeat (600) @(posedge clk_i);
    rd(8'h1b, s);
    chk(s, 8'h0c, "glitch filtered");
  endtask
  task report_and_stop;
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    tx_one(8'hee, 8'ha5);
    tx_one(8'hfe, 8'h3c);
    tx_one(8'hc6, 8'h81);
    t_rx();
    t_pins();
    u_far.bit_ns = 1664;
    tx_one(8'hc8, 8'hb4);
    u_far.bit_ns = 12288;
    tx_one(8'hcf, 8'h4b);
    u_far.bit_ns = 256;
    t_framing();
    report_and_stop();
  end
  initial begin
    #600000;
    err_total++;
    report_and_stop();
  end
endmodule // asu_uart_tb
